// File: rtl/cfg_pins_ctrl.sv
// configuration, power-down and status pin sequencer of the programmable logic device
//
// Notes on behaviour
// - power-down pin low enters low-power state
// - power-down disables io, holds flops initialised
// - inputs read as low during power-down
// - configuration kept through power-down, no reload
// - power-down suspends configuration, restarts on release
// - on release, inputs and flops before outputs
// - no scan: test data output plain three-state
// - test pins come straight from pads
// - high-during-config driven high until io active
// - low-during-config driven low until io active
// - init line low during stabilise and clear
// - external low on init holds wait state
// - master mode waits extra 30 to 300 us
// - init pulled low on configuration data error
// - after io active, init is user pin
// - global clock pins feed nets or user
// - clear release: finish pass, one more, wait
`timescale 1ns/1ps
module cfg_pins_ctrl
	import cfg_pins_pkg::*;
#(
	parameter int IO_N   = 8,
	parameter int GCLK_N = 4
) (
	// clock and reset
	input  wire logic                core_clk_in,
	input  wire logic                rstn_in,
	// asynchronous pins
	input  wire logic                power_down_n_in,
	input  wire logic                config_clear_n_in,
	input  wire logic                init_n_in,
	input  wire logic                tdi_pin_in,
	input  wire logic                tck_pin_in,
	input  wire logic                tms_pin_in,
	input  wire logic [GCLK_N-1:0]   primary_global_clock_inputs_in,
	input  wire logic [IO_N-1:0]     user_pin_in,
	// configuration options and loader status
	input  wire logic                master_mode_in,
	input  wire logic                scan_element_used_in,
	input  wire logic [GCLK_N-1:0]   global_buffer_used_in,
	input  wire logic                config_error_in,
	input  wire logic                config_done_in,
	// user logic drive requests
	input  wire logic [IO_N-1:0]     user_out_in,
	input  wire logic [IO_N-1:0]     user_oe_in,
	input  wire status_pins_s        user_status_in,
	input  wire logic                user_tdo_in,
	input  wire logic                user_tdo_oe_in,
	// boundary-scan element
	input  wire logic                scan_tdo_in,
	input  wire logic                scan_tdo_oe_in,
	// pin drive
	output status_pins_s             status_pins_out,
	output logic                     tdo_out,
	output logic                     tdo_oe_out,
	output logic [IO_N-1:0]          user_pin_out,
	output logic [IO_N-1:0]          user_pin_oe_out,
	// internal distribution
	output logic [IO_N-1:0]          user_in_out,
	output test_pins_s               scan_test_out,
	output test_pins_s               test_user_out,
	output logic [GCLK_N-1:0]        global_net_out,
	output logic [GCLK_N-1:0]        gclk_user_out,
	// sequencer status
	output logic                     clear_mem_out,
	output logic                     config_run_out,
	output logic                     config_restart_out,
	output logic                     flops_init_out,
	output logic                     power_down_active_out
);

	localparam int SYNC_W = SYNC_FIXED + GCLK_N + IO_N;

	// ----------------------------------------
	// decoding shared by several blocks
	// ----------------------------------------
	function automatic logic io_active(input seq_state_e s);
		io_active = (s == ST_USER);
	endfunction : io_active

	function automatic logic configured(input seq_state_e s);
		configured = (s == ST_INPUTS_ON) || (s == ST_USER) || (s == ST_DOWN);
	endfunction : configured

	// ----------------------------------------
	// pin synchronisation
	// ----------------------------------------
	logic [SYNC_W-1:0] pins_async;
	logic [SYNC_W-1:0] pins_sync;

	assign pins_async = {user_pin_in, primary_global_clock_inputs_in, tms_pin_in, tck_pin_in,
		tdi_pin_in, init_n_in, config_clear_n_in, power_down_n_in};

	pin_sync #(
		.WIDTH       (SYNC_W)
	) u_sync (
		.core_clk_in (core_clk_in),
		.rstn_in     (rstn_in),
		.async_in    (pins_async),
		.sync_out    (pins_sync)
	);

	logic              pd_n_s;
	logic              clr_n_s;
	logic              init_n_s;
	test_pins_s        test_s;
	logic [GCLK_N-1:0] gclk_s;
	logic [IO_N-1:0]   user_s;

	assign pd_n_s   = pins_sync[SYNC_PD];
	assign clr_n_s  = pins_sync[SYNC_CLR];
	assign init_n_s = pins_sync[SYNC_INIT];
	assign test_s   = '{tdi: pins_sync[SYNC_TDI], tck: pins_sync[SYNC_TCK], tms: pins_sync[SYNC_TMS]};
	assign gclk_s   = pins_sync[SYNC_FIXED +: GCLK_N];
	assign user_s   = pins_sync[SYNC_FIXED + GCLK_N +: IO_N];

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	seq_state_e       state_q;
	seq_state_e       state_d;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             err_q;
	logic             err_d;

	// next state; outside stabilise, power-down outranks everything, then the clear request
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q + 1'b1;
		err_d   = err_q;
		case (state_q)
			ST_STABILIZE: begin
				if (cnt_q == CNT_W'(STAB_CYCLES - 1)) begin
					state_d = ST_CLEAR;
					cnt_d   = '0;
				end
			end
			ST_CLEAR: begin
				if (cnt_q == CNT_W'(CLEAR_PASS_CYCLES - 1)) begin
					cnt_d = '0;
					if (clr_n_s) begin
						state_d = ST_CLEAR_LAST;
					end
				end
			end
			ST_CLEAR_LAST: begin
				if (cnt_q == CNT_W'(CLEAR_PASS_CYCLES - 1)) begin
					state_d = ST_WAIT;
					cnt_d   = '0;
				end
			end
			ST_WAIT: begin
				cnt_d = '0;
				if (init_n_s) begin
					state_d = master_mode_in ? ST_MASTER : ST_CONFIG;
				end
			end
			ST_MASTER: begin
				if (!init_n_s) begin
					state_d = ST_WAIT;
				end else if (cnt_q == CNT_W'(MASTER_WAIT_CYCLES - 1)) begin
					state_d = ST_CONFIG;
				end
			end
			ST_CONFIG: begin
				if (config_error_in) begin
					err_d = 1'b1;
				end
				if (config_done_in && !err_q && !config_error_in) begin
					state_d = ST_INPUTS_ON;
				end
			end
			ST_SUSPEND: begin
				if (pd_n_s) begin
					state_d = ST_WAIT;
				end
			end
			ST_INPUTS_ON: begin
				state_d = ST_USER;
			end
			ST_USER: begin
				state_d = ST_USER;
			end
			ST_DOWN: begin
				if (pd_n_s) begin
					state_d = ST_INPUTS_ON;
				end
			end
			default: begin
				state_d = ST_STABILIZE;
				cnt_d   = '0;
			end
		endcase
		if (!pd_n_s && state_q != ST_STABILIZE) begin
			state_d = configured(state_q) ? ST_DOWN : ST_SUSPEND;
			cnt_d   = '0;
		end else if (!clr_n_s && state_q != ST_STABILIZE && state_q != ST_CLEAR) begin
			// a new clear request wipes the loaded contents and any error
			state_d = ST_CLEAR;
			cnt_d   = '0;
			err_d   = 1'b0;
		end
		if (state_d == ST_CLEAR && state_q != ST_CLEAR) begin
			err_d = 1'b0;
		end
	end

	// sequencer registers
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			state_q <= ST_STABILIZE;
			cnt_q   <= '0;
			err_q   <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			err_q   <= err_d;
		end
	end

	// ----------------------------------------
	// pin and distribution outputs
	// ----------------------------------------
	status_pins_s      status_d;
	logic              tdo_d;
	logic              tdo_oe_d;
	logic [IO_N-1:0]   upin_d;
	logic [IO_N-1:0]   upin_oe_d;
	logic [IO_N-1:0]   uin_d;
	test_pins_s        scan_test_d;
	test_pins_s        test_user_d;
	logic [GCLK_N-1:0] gnet_d;
	logic [GCLK_N-1:0] guser_d;
	logic              in_on;
	logic              out_on;

	// outputs decode from the next state so pins follow the sequencer without extra lag
	always_comb begin
		in_on  = (state_d == ST_INPUTS_ON) || io_active(state_d);
		out_on = io_active(state_d);
		status_d = STATUS_RESET;
		status_d.init_oe = (state_d == ST_STABILIZE) || (state_d == ST_CLEAR) || (state_d == ST_CLEAR_LAST);
		if (state_d == ST_CONFIG && err_d) begin
			status_d.init_oe = 1'b1;
		end
		if (out_on) begin
			status_d = user_status_in;
		end else if (state_d == ST_DOWN) begin
			// status pins released with the rest of the io
			status_d = '0;
			status_d.init_n = 1'b1;
		end
		upin_d    = out_on ? user_out_in : '0;
		upin_oe_d = out_on ? user_oe_in : '0;
		uin_d     = in_on ? user_s : '0;
		scan_test_d = pd_n_s ? test_s : TEST_IDLE;
		test_user_d = (in_on && configured(state_d)) ? test_s : TEST_IDLE;
		if (configured(state_d) && !scan_element_used_in) begin
			scan_test_d = TEST_IDLE;
		end
		if (scan_element_used_in) begin
			tdo_d    = scan_tdo_in;
			tdo_oe_d = pd_n_s && scan_tdo_oe_in;
		end else begin
			tdo_d    = user_tdo_in;
			tdo_oe_d = out_on && user_tdo_oe_in;
		end
		gnet_d  = in_on ? (gclk_s & global_buffer_used_in) : '0;
		guser_d = in_on ? (gclk_s & ~global_buffer_used_in) : '0;
	end

	// output registers
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			status_pins_out       <= STATUS_RESET;
			tdo_out               <= 1'b0;
			tdo_oe_out            <= 1'b0;
			user_pin_out          <= '0;
			user_pin_oe_out       <= '0;
			user_in_out           <= '0;
			scan_test_out         <= TEST_IDLE;
			test_user_out         <= TEST_IDLE;
			global_net_out        <= '0;
			gclk_user_out         <= '0;
			clear_mem_out         <= 1'b0;
			config_run_out        <= 1'b0;
			config_restart_out    <= 1'b0;
			flops_init_out        <= 1'b1;
			power_down_active_out <= 1'b0;
		end else begin
			status_pins_out       <= status_d;
			tdo_out               <= tdo_d;
			tdo_oe_out            <= tdo_oe_d;
			user_pin_out          <= upin_d;
			user_pin_oe_out       <= upin_oe_d;
			user_in_out           <= uin_d;
			scan_test_out         <= scan_test_d;
			test_user_out         <= test_user_d;
			global_net_out        <= gnet_d;
			gclk_user_out         <= guser_d;
			clear_mem_out         <= (state_d == ST_CLEAR) || (state_d == ST_CLEAR_LAST);
			config_run_out        <= (state_d == ST_CONFIG);
			config_restart_out    <= (state_d == ST_CONFIG) && (state_q != ST_CONFIG);
			flops_init_out        <= !((state_d == ST_INPUTS_ON) || io_active(state_d));
			power_down_active_out <= (state_d == ST_DOWN) || (state_d == ST_SUSPEND);
		end
	end

endmodule : cfg_pins_ctrl

// File: rtl/cfg_pins_pkg.sv
// constants, states and pin bundles for the configuration and power-down pin logic
package cfg_pins_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_MHZ            = 100;              // core clock rate
	localparam int MASTER_WAIT_US     = 30;               // least extra wait for master mode
	localparam int MASTER_WAIT_CYCLES = MASTER_WAIT_US * CLK_MHZ;
	localparam int STAB_CYCLES        = 16;               // power stabilisation model length
	localparam int CLEAR_PASS_CYCLES  = 64;               // one configuration memory clear pass
	localparam int CNT_W              = 16;

	// ----------------------------------------
	// synchroniser vector layout
	// ----------------------------------------
	localparam int SYNC_PD    = 0;
	localparam int SYNC_CLR   = 1;
	localparam int SYNC_INIT  = 2;
	localparam int SYNC_TDI   = 3;
	localparam int SYNC_TCK   = 4;
	localparam int SYNC_TMS   = 5;
	localparam int SYNC_FIXED = 6;                        // first global clock bit

	// ----------------------------------------
	// sequencer states
	// ----------------------------------------
	typedef enum logic [3:0] {
		ST_STABILIZE  = 4'h0,
		ST_CLEAR      = 4'h1,
		ST_CLEAR_LAST = 4'h2,
		ST_WAIT       = 4'h3,
		ST_MASTER     = 4'h4,
		ST_CONFIG     = 4'h5,
		ST_SUSPEND    = 4'h6,
		ST_INPUTS_ON  = 4'h7,
		ST_USER       = 4'h8,
		ST_DOWN       = 4'h9
	} seq_state_e;

	// ----------------------------------------
	// pin bundles
	// ----------------------------------------
	typedef struct packed {
		logic high_during_config;
		logic hdc_oe;
		logic low_during_config_n;
		logic ldc_oe;
		logic init_n;
		logic init_oe;
	} status_pins_s;

	typedef struct packed {
		logic tdi;
		logic tck;
		logic tms;
	} test_pins_s;

	localparam status_pins_s STATUS_RESET = '{
		high_during_config: 1'b1, hdc_oe: 1'b1,
		low_during_config_n: 1'b0, ldc_oe: 1'b1,
		init_n: 1'b0, init_oe: 1'b1};
	localparam test_pins_s TEST_IDLE = '{tdi: 1'b0, tck: 1'b0, tms: 1'b0};

endpackage : cfg_pins_pkg

// File: rtl/pin_sync.sv
// two-flop synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             core_clk_in,
	input  wire logic             rstn_in,
	// levels
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] meta_d;
	logic [WIDTH-1:0] sync_q;
	logic [WIDTH-1:0] sync_d;

	// first stage is read only by the second stage
	always_comb begin
		meta_d = async_in;
		sync_d = meta_q;
	end

	// reset parks both stages low, pins are treated as low until sampled
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_out = sync_q;

endmodule : pin_sync

// File: verification/board_model.sv
// board-side partner: power-down and clear drivers plus the pulled-up wired lines
`timescale 1ns/1ps
module board_model
	import cfg_pins_pkg::*;
(
	// clock and requests {hold init low, clear, power-down}
	input  wire logic         core_clk_in,
	input  wire logic [2:0]   req_in,
	// device drive
	input  wire status_pins_s status_pins_in,
	input  wire logic [7:0]   pin_out_in,
	input  wire logic [7:0]   pin_oe_in,
	// board levels
	output logic              power_down_n_out,
	output logic              config_clear_n_out,
	output logic              init_wire_out,
	output logic [7:0]        pin_wire_out
);
	logic [2:0] req_q = 3'h0;

	// requests change just after an edge, like board logic on the same clock
	always @(posedge core_clk_in) req_q <= req_in;
	assign power_down_n_out   = !req_q[0];
	assign config_clear_n_out = !req_q[1];
	// external hold of the wait state
	assign init_wire_out = !(req_q[2] || (status_pins_in.init_oe && !status_pins_in.init_n));
	// released user pins float up to the pull-up level
	assign pin_wire_out = (pin_out_in & pin_oe_in) | ~pin_oe_in;
endmodule : board_model

// File: verification/cfg_pins_monitor.sv
// concurrent checks on the configuration and power-down pin sequencer ports
`timescale 1ns/1ps
module cfg_pins_monitor
	import cfg_pins_pkg::*;
#(
	parameter int IO_N = 8
) (
	// clock and reset
	input wire logic            core_clk_in,
	input wire logic            rstn_in,
	// pins and options
	input wire logic            power_down_n_in,
	input wire logic            config_clear_n_in,
	input wire logic            init_n_in,
	input wire logic            master_mode_in,
	input wire logic            scan_element_used_in,
	input wire logic            config_error_in,
	input wire logic            user_tdo_in,
	input wire logic [IO_N-1:0] user_oe_in,
	// design outputs
	input wire status_pins_s    status_pins_out,
	input wire logic            tdo_out,
	input wire logic [IO_N-1:0] user_pin_oe_out,
	input wire logic [IO_N-1:0] user_in_out,
	input wire logic            clear_mem_out,
	input wire logic            config_run_out,
	input wire logic            config_restart_out,
	input wire logic            flops_init_out,
	input wire logic            power_down_active_out
);
	logic [12:0] high_q;
	logic [12:0] high_d;

	// run length of a high init line, saturating so a long run never wraps
	always_comb begin
		high_d = init_n_in ? (high_q + {12'h0, ~&high_q}) : 13'h0;
	end
	always_ff @(posedge core_clk_in) begin
		high_q <= rstn_in ? high_d : 13'h0;
	end

	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);

	// release steps: inputs first with outputs off, outputs one cycle later
	sequence outputs_off;
		user_pin_oe_out == '0;
	endsequence
	sequence outputs_follow;
		user_pin_oe_out == $past(user_oe_in);
	endsequence

	hdc_config_a:
	assert property (flops_init_out && !power_down_active_out |-> status_pins_out.high_during_config
		&& status_pins_out.hdc_oe) else $error("hdc not driven high");
	ldc_config_a:
	assert property (flops_init_out && !power_down_active_out |-> !status_pins_out.low_during_config_n
		&& status_pins_out.ldc_oe) else $error("ldc not driven low");
	clear_init_a:
	assert property (clear_mem_out |-> status_pins_out.init_oe && !status_pins_out.init_n)
		else $error("init released while clearing");
	down_inputs_a:
	assert property (power_down_active_out |-> user_in_out == '0 && user_pin_oe_out == '0 && flops_init_out)
		else $error("io live in power-down");
	down_entry_a:
	assert property ($fell(power_down_n_in) && !flops_init_out ##1 !power_down_n_in [*3]
		|-> power_down_active_out) else $error("power-down not entered");
	release_order_a:
	assert property ($fell(flops_init_out) |-> outputs_off ##1 outputs_follow)
		else $error("outputs before inputs");
	clear_tail_a:
	assert property ($rose(config_clear_n_in) && clear_mem_out |-> ##60 clear_mem_out ##[1:80] !clear_mem_out)
		else $error("clear tail length wrong");
	init_free_a:
	assert property ($fell(clear_mem_out) && !power_down_active_out |-> !status_pins_out.init_oe)
		else $error("init kept after clear");
	wait_hold_a:
	assert property ($rose(config_run_out) |-> config_restart_out && high_q >= 13'h2)
		else $error("config left wait early");
	master_wait_a:
	assert property ($rose(config_run_out) && master_mode_in |-> high_q >= 13'(MASTER_WAIT_CYCLES))
		else $error("master wait too short");
	data_error_a:
	assert property (config_error_in && config_run_out |=> (status_pins_out.init_oe && !status_pins_out.init_n)[*4])
		else $error("data error not shown");
	tdo_plain_a:
	assert property (!flops_init_out && !scan_element_used_in ##1
		(!flops_init_out && !power_down_active_out && !scan_element_used_in)
		|-> tdo_out == $past(user_tdo_in)) else $error("tdo not user data");
endmodule : cfg_pins_monitor

// File: verification/tb.sv
// self-checking bench for the configuration and power-down pin sequencer
`timescale 1ns/1ps
module tb;
	import cfg_pins_pkg::*;

	logic core_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic power_down_n_in, config_clear_n_in, init_n_in, tdi_pin_in, tck_pin_in, tms_pin_in;
	logic master_mode_in = 1'b0;
	logic scan_element_used_in = 1'b0;
	logic config_error_in = 1'b0;
	logic config_done_in = 1'b0;
	logic user_tdo_in, user_tdo_oe_in, scan_tdo_in, scan_tdo_oe_in;
	logic [3:0] primary_global_clock_inputs_in, global_buffer_used_in, global_net_out, gclk_user_out;
	logic [7:0] user_pin_in, user_out_in, user_oe_in, user_pin_out, user_pin_oe_out, user_in_out;
	status_pins_s user_status_in, status_pins_out;
	test_pins_s scan_test_out, test_user_out;
	logic tdo_out, tdo_oe_out, clear_mem_out, config_run_out, config_restart_out, flops_init_out;
	logic power_down_active_out;
	logic [2:0] req = 3'h0;
	logic [26:0] exp_q[$];
	int err_count = 0;
	int tests_run = 0;
	int restarts = 0;
	int base;
	event probe;
	wire [26:0] obs = {user_in_out, user_pin_oe_out, gclk_user_out, global_net_out, test_user_out};

	always #5 core_clk_in = ~core_clk_in;
	cfg_pins_ctrl i_dut (.*);
	board_model i_board (.core_clk_in, .req_in(req), .status_pins_in(status_pins_out), .pin_out_in(user_pin_out),
		.pin_oe_in(user_pin_oe_out), .power_down_n_out(power_down_n_in), .config_clear_n_out(config_clear_n_in),
		.init_wire_out(init_n_in), .pin_wire_out(user_pin_in));

	// pulses are counted mid-cycle, away from the edge where they change
	always @(negedge core_clk_in) if (config_restart_out === 1'b1) restarts++;
	// oldest note against the pins once they have settled
	always @(probe) begin
		#2;
		check("pins seen by logic", obs, exp_q.pop_front());
	end

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_in);
		#1;
	endtask : cyc

	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict

	// bounded wait on one sequencer flag: 0 down, 1 clear, 2 flops held, 3 run
	task automatic wait_for(input int sel, input logic val, input int lim);
		logic [3:0] w;
		for (int i = 0; i < lim; i++) begin
			w = {config_run_out, flops_init_out, clear_mem_out, power_down_active_out};
			if (w[sel] === val) return;
			cyc(1);
		end
		check("wait bound", 0, 1);
		give_verdict();
	endtask : wait_for

	task automatic rnd();
		{user_out_in, user_oe_in, primary_global_clock_inputs_in, global_buffer_used_in} = 24'($urandom);
		{tdi_pin_in, tck_pin_in, tms_pin_in, user_tdo_in, user_tdo_oe_in, scan_tdo_in, scan_tdo_oe_in} = 7'($urandom);
		user_status_in = status_pins_s'(6'($urandom));
	endtask : rnd

	task automatic expect_obs(input logic [26:0] e);
		exp_q.push_back(e);
		-> probe;
		cyc(1);
	endtask : expect_obs

	// live view: pin wires, user enables, split global pins, test pins
	function automatic logic [26:0] live();
		logic [3:0] g;
		g = primary_global_clock_inputs_in;
		return {(user_out_in & user_oe_in) | ~user_oe_in, user_oe_in, g & ~global_buffer_used_in,
			g & global_buffer_used_in, tdi_pin_in, tck_pin_in, tms_pin_in};
	endfunction : live

	initial begin
		void'($urandom(32'h5185));
		rnd();
		repeat (12) @(posedge core_clk_in);
		#1;
		check("reset pins", status_pins_out, STATUS_RESET);
		rstn_in = 1'b1;
		wait_for(1, 1'b1, 100);
		req[2] = 1'b1;
		wait_for(1, 1'b0, 400);
		cyc(50);
		check("held in wait", config_run_out, 1'b0);
		req[2] = 1'b0;
		wait_for(3, 1'b1, 20);
		config_done_in = 1'b1;
		wait_for(2, 1'b0, 20);
		cyc(4);
		expect_obs(live());
		check("user status", status_pins_out, user_status_in);
		check("user drive", user_pin_out, user_out_in);
		check("tdo", {tdo_out, tdo_oe_out}, {user_tdo_in, user_tdo_oe_in});
		check("scan off", scan_test_out, TEST_IDLE);
		// a placed scan element takes back the test data output and the test pins
		scan_element_used_in = 1'b1;
		cyc(1);
		check("scan tdo", {tdo_out, tdo_oe_out}, {scan_tdo_in, scan_tdo_oe_in});
		check("scan pins", scan_test_out, {tdi_pin_in, tck_pin_in, tms_pin_in});
		scan_element_used_in = 1'b0;
		cyc(1);
		base = restarts;
		req[0] = 1'b1;
		wait_for(0, 1'b1, 10);
		rnd();
		cyc(4);
		expect_obs(27'h0);
		req[0] = 1'b0;
		wait_for(2, 1'b0, 20);
		cyc(4);
		expect_obs(live());
		check("no reload", restarts, base);
		config_done_in = 1'b0;
		req[1] = 1'b1;
		cyc(150);
		req[1] = 1'b0;
		wait_for(1, 1'b0, 200);
		wait_for(3, 1'b1, 20);
		config_error_in = 1'b1;
		cyc(1);
		config_error_in = 1'b0;
		cyc(3);
		check("error on init", init_n_in, 1'b0);
		config_done_in = 1'b1;
		cyc(20);
		check("done refused", flops_init_out, 1'b1);
		config_done_in = 1'b0;
		master_mode_in = 1'b1;
		req[1] = 1'b1;
		cyc(5);
		req[1] = 1'b0;
		wait_for(3, 1'b1, 3400);
		req[0] = 1'b1;
		wait_for(0, 1'b1, 10);
		check("suspended", config_run_out, 1'b0);
		base = restarts;
		req[0] = 1'b0;
		wait_for(3, 1'b1, 3400);
		// the pulse is counted at the falling edge, so let it pass first
		cyc(1);
		check("restarted", restarts, base + 1);
		config_done_in = 1'b1;
		wait_for(2, 1'b0, 20);
		give_verdict();
	end
endmodule : tb

bind cfg_pins_ctrl cfg_pins_monitor #(.IO_N(IO_N)) i_mon (.*);
